// File: bench/sgp_partner.sv
/*
  sgp_partner: behavioural sub-controller and legacy peripherals.
  assumes the bench pulses clear_cmd_i for one cycle to ask for a reset;
  hold time is a parameter, shortened from the real figure.
*/
`timescale 1ns/10ps
module sgp_partner #(
  parameter int unsigned HOLD_CYC = 8
) (
  // clock and commands from the bench
  input  wire logic core_clk_i,
  input  wire logic clear_cmd_i,
  input  wire logic key_i,
  input  wire logic periph_irq_i,
  // pins toward the glue block
  output logic      reset_in_n_o,
  output logic      break_key_in_o,
  output logic      irq_req_o
);
  // starts loaded: power-on also holds the reset pin low
  int unsigned cnt = HOLD_CYC;

  always @(posedge core_clk_i) begin
    if (clear_cmd_i) begin
      cnt <= HOLD_CYC;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end

  assign reset_in_n_o   = (cnt == 0);
  assign break_key_in_o = key_i;
  // active high, line pulled down when no peripheral requests
  assign irq_req_o      = periph_irq_i;
endmodule

// File: bench/test_system_glue_pin_logic.sv
/*
  test_system_glue_pin_logic: directed bench for sgp_glue with partner.
  assumes pin paths settle within six enabled edges; strobe pin pulled up.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  err_count++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module test_system_glue_pin_logic;
  import sgp_pkg::*;
  localparam int unsigned HOLD = 8;
  logic         clk = 0;
  logic         srst = 1;
  sgp_buzz_in_t buzz = '1;
  sgp_cpu_t     cpu = SGP_CPU_LEGACY;
  logic         pin_en = 0;
  logic         pin_drv = 0;
  logic         nm = 0;
  sgp_wr_t      wr = '0;
  logic         cmd_rst = 0;
  logic         key = 0;
  logic         irq = 0;
  logic         en = 1;
  logic         rst_n_pin, key_pin, irq_pin, strobe_wire;
  logic         buzzer_out_o, tape_rec_out_o, cpu_select_ind_o;
  logic         strobe_pin_o, strobe_pin_oe_o, strobe_capture_ff_o;
  logic         reset_req_o, break_key_o, irq_legacy_o, irq_primary_o;
  int           err_count = 0;
  int           checks_done = 0;

  always #25 clk = ~clk;
  // released pin falls back to the external pull-up
  assign strobe_wire = strobe_pin_oe_o ? strobe_pin_o
                     : (pin_en ? pin_drv : 1'b1);

  sgp_partner #(.HOLD_CYC(HOLD)) partner_u (.core_clk_i(clk),
    .clear_cmd_i(cmd_rst), .key_i(key), .periph_irq_i(irq),
    .reset_in_n_o(rst_n_pin), .break_key_in_o(key_pin),
    .irq_req_o(irq_pin));

  sgp_glue dut_u (.core_clk_i(clk), .srst_i(srst), .clk_en_i(en),
    .buzz_i(buzz), .buzzer_out_o(buzzer_out_o),
    .tape_rec_out_o(tape_rec_out_o), .cpu_active_i(cpu),
    .cpu_select_ind_o(cpu_select_ind_o), .strobe_pin_i(strobe_wire),
    .strobe_pin_o(strobe_pin_o), .strobe_pin_oe_o(strobe_pin_oe_o),
    .normal_mode_i(nm), .strobe_capture_ff_o(strobe_capture_ff_o),
    .wr_i(wr), .reset_in_n_i(rst_n_pin), .reset_req_o(reset_req_o),
    .break_key_in_i(key_pin), .break_key_o(break_key_o),
    .irq_req_i(irq_pin), .irq_legacy_o(irq_legacy_o),
    .irq_primary_o(irq_primary_o));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input int n);
    srst = 1;
    step(n);
    srst = 0;
  endtask

  // idle edge after each pulse so back-to-back calls never glitch wr
  task automatic wr_pulse(input sgp_wr_t w);
    wr = w;
    step(1);
    wr = '0;
    step(1);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one mix input low at a time, then all high
  task automatic t_buzz;
    sgp_buzz_in_t pat;
    for (int i = 0; i < 5; i++) begin
      pat = '1;
      if (i < 4) pat[3-i] = 1'b0;
      buzz = pat;
      step(6);
      `CHK("buzzer", logic'(i < 4), buzzer_out_o)
      `CHK("tape_rec", ~pat.tape_rec_legacy_n, tape_rec_out_o)
    end
    $display("done buzz");
  endtask

  // enable low must hold the buzzer output, then the held change goes through
  task automatic t_freeze;
    en = 0;
    buzz.tape_play_in = 1'b0;
    step(6);
    `CHK("buzz_frozen", 1'b0, buzzer_out_o)
    en = 1;
    step(6);
    `CHK("buzz_thawed", 1'b1, buzzer_out_o)
    buzz = '1;
    step(6);
    `CHK("buzz_quiet", 1'b0, buzzer_out_o)
    $display("done freeze");
  endtask

  task automatic t_cpu;
    cpu = SGP_CPU_LEGACY;
    irq = 1;
    step(7);
    `CHK("ind_legacy", 1'b0, cpu_select_ind_o)
    `CHK("irq_legacy", 1'b1, irq_legacy_o)
    `CHK("irq_prim_off", 1'b0, irq_primary_o)
    cpu = SGP_CPU_PRIMARY;
    step(2);
    `CHK("ind_primary", 1'b1, cpu_select_ind_o)
    `CHK("irq_primary", 1'b1, irq_primary_o)
    `CHK("irq_leg_off", 1'b0, irq_legacy_o)
    irq = 0;
    step(6);
    `CHK("irq_idle", 1'b0, irq_primary_o)
    $display("done cpu");
  endtask

  task automatic t_strobe;
    pin_en = 0;
    do_reset(6);
    `CHK("capture_hi", 1'b1, strobe_capture_ff_o)
    `CHK("oe_reset", 1'b0, strobe_pin_oe_o)
    pin_en = 1;
    step(1);
    do_reset(6);
    pin_drv = 1;
    step(6);
    `CHK("capture_lo", 1'b0, strobe_capture_ff_o)
    nm = 1;
    step(1);
    `CHK("oe_normal", 1'b1, strobe_pin_oe_o)
    wr_pulse('{1'b1, 8'h19, 1'b0, 1'b0, 16'h0});
    wr_pulse('{1'b0, 8'h0, 1'b1, 1'b0, STROBE_MEM_ADDR});
    wr_pulse('{1'b0, 8'h0, 1'b1, 1'b1, 16'hf009});
    `CHK("strobe_other", 1'b0, strobe_pin_o)
    wr_pulse('{1'b1, STROBE_IO_ADDR, 1'b0, 1'b0, 16'h0});
    `CHK("strobe_io", 1'b1, strobe_pin_o)
    `CHK("strobe_wire", 1'b1, strobe_wire)
    do_reset(2);
    `CHK("strobe_rst", 1'b0, strobe_pin_o)
    wr_pulse('{1'b0, 8'h0, 1'b1, 1'b1, STROBE_MEM_ADDR});
    `CHK("strobe_mem", 1'b1, strobe_pin_o)
    $display("done strobe");
  endtask

  task automatic t_partner;
    int n;
    key = 1;
    cmd_rst = 1;
    step(1);
    cmd_rst = 0;
    for (n = 0; n < 20 && reset_req_o !== 1'b1; n++) step(1);
    if (reset_req_o !== 1'b1) begin
      err_count++;
      $display("MISMATCH reset_req exp 1 got timeout");
    end else begin
      `CHK("break_key", 1'b1, break_key_o)
      step(HOLD + 6);
      `CHK("reset_release", 1'b0, reset_req_o)
    end
    $display("done partner");
  endtask

  initial begin
    do_reset(5);
    t_buzz;
    t_freeze;
    t_cpu;
    t_strobe;
    t_partner;
    conclude;
  end
endmodule

// File: core/sgp_glue.sv
/*
  sgp_glue: pin-level glue of the system controller: buzzer mix, tape
  record output, processor indicator, strobe pin, reset and interrupt
  inputs.
  assumes processor write strobes arrive on core_clk_i as one-cycle
  pulses; all pins from outside pass the three-stage synchroniser.
*/
// What this block does
// - buzzer high when any mix input low
// - input one playback, input two beep disable
// - legacy tape record on its own pin
// - indicator low legacy cpu, high primary
// - strobe pin input, level captured during reset
// - strobe pin becomes output after reset while normal_mode_i is high
// - strobe high on port write 18h or on memory write f008h in memory space one
// - high request interrupts the active processor
`timescale 1ns/10ps
module sgp_glue
  import sgp_pkg::*;
(
  // clock, reset, enable
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic         clk_en_i,
  // buzzer and tape
  input  wire sgp_buzz_in_t buzz_i,
  output logic              buzzer_out_o,
  output logic              tape_rec_out_o,
  // processor selection
  input  wire sgp_cpu_t     cpu_active_i,
  output logic              cpu_select_ind_o,
  // strobe pin, its three signals, mode, capture and write inputs
  input  wire logic         strobe_pin_i,
  output logic              strobe_pin_o,
  output logic              strobe_pin_oe_o,
  input  wire logic         normal_mode_i,
  output logic              strobe_capture_ff_o,
  input  wire sgp_wr_t      wr_i,
  // reset, break key and interrupt pins
  input  wire logic         reset_in_n_i,
  output logic              reset_req_o,
  input  wire logic         break_key_in_i,
  output logic              break_key_o,
  input  wire logic         irq_req_i,
  output logic              irq_legacy_o,
  output logic              irq_primary_o
);

  logic [PIN_IN_W-1:0] pin_raw;
  logic [PIN_IN_W-1:0] pin_sync;
  logic                tape_play_s;
  logic                beep_dis_n_s;
  logic                rec_new_n_s;
  logic                rec_leg_n_s;
  logic                reset_n_s;
  logic                irq_s;
  logic                brk_raw;

  assign pin_raw = {buzz_i.tape_play_in, buzz_i.beep_disable_n,
                    buzz_i.tape_rec_new_n, buzz_i.tape_rec_legacy_n,
                    reset_in_n_i, irq_req_i};

  // idle-high pins reset to one so nothing beeps or resets spuriously
  sgp_sync #(
    .WIDTH   (PIN_IN_W),
    .RST_VAL (6'h3e)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .clk_en_i   (clk_en_i),
    .async_i    (pin_raw),
    .sync_o     (pin_sync)
  );

  assign {tape_play_s, beep_dis_n_s, rec_new_n_s, rec_leg_n_s,
          reset_n_s, irq_s} = pin_sync;

  sgp_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_sync_brk (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .clk_en_i   (clk_en_i),
    .async_i    (break_key_in_i),
    .sync_o     (brk_raw)
  );

  // output registers
  logic buzzer;
  logic next_buzzer;
  logic tape_rec;
  logic next_tape_rec;
  logic cpu_ind;
  logic next_cpu_ind;
  logic reset_req;
  logic next_reset_req;
  logic brk;
  logic next_brk;
  logic irq_leg;
  logic next_irq_leg;
  logic irq_pri;
  logic next_irq_pri;

  always_comb begin
    // any low input sounds; all high is silence
    next_buzzer   = ~(tape_play_s & beep_dis_n_s &
                      rec_new_n_s & rec_leg_n_s);
    next_tape_rec = ~rec_leg_n_s;
    next_cpu_ind  = (cpu_active_i == SGP_CPU_PRIMARY);
    next_reset_req = ~reset_n_s;
    next_brk      = brk_raw;
    next_irq_leg  = irq_s & (cpu_active_i == SGP_CPU_LEGACY);
    next_irq_pri  = irq_s & (cpu_active_i == SGP_CPU_PRIMARY);
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      buzzer    <= 1'b0;
      tape_rec  <= 1'b0;
      cpu_ind   <= 1'b0;
      reset_req <= 1'b0;
      brk       <= 1'b0;
      irq_leg   <= 1'b0;
      irq_pri   <= 1'b0;
    end else if (clk_en_i) begin
      buzzer    <= next_buzzer;
      tape_rec  <= next_tape_rec;
      cpu_ind   <= next_cpu_ind;
      reset_req <= next_reset_req;
      brk       <= next_brk;
      irq_leg   <= next_irq_leg;
      irq_pri   <= next_irq_pri;
    end
  end

  assign buzzer_out_o     = buzzer;
  assign tape_rec_out_o   = tape_rec;
  assign cpu_select_ind_o = cpu_ind;
  assign reset_req_o      = reset_req;
  assign break_key_o      = brk;
  assign irq_legacy_o     = irq_leg;
  assign irq_primary_o    = irq_pri;

  // strobe pin: sampled in reset, driven afterwards while normal_mode_i is high
  logic strb_s1;
  logic strb_s2;
  logic strb_s3;
  logic capture;
  logic next_capture;
  logic strobe_out;
  logic next_strobe_out;
  logic strobe_oe;
  logic next_strobe_oe;
  logic strobe_hit;

  // strobe stays high once set until reset; no clearing write exists
  assign strobe_hit =
    (wr_i.io_wr && wr_i.io_addr == STROBE_IO_ADDR) ||
    (wr_i.mem_wr && wr_i.mem_space_one &&
     wr_i.mem_addr == STROBE_MEM_ADDR);

  always_comb begin
    next_capture    = capture;
    next_strobe_out = strobe_out;
    next_strobe_oe  = strobe_oe;
    if (srst_i) begin
      // latch the pin while reset holds; synchroniser stages agree first
      next_capture    = (strb_s2 == strb_s3) ? strb_s3 : capture;
      next_strobe_out = STROBE_OUT_RST;
      next_strobe_oe  = 1'b0;
    end else begin
      next_strobe_oe = normal_mode_i;
      if (strobe_hit) begin
        next_strobe_out = 1'b1;
      end
    end
  end

  // reset does not clear the capture flop: it samples the pin instead
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i) begin
      strb_s1    <= strobe_pin_i;
      strb_s2    <= strb_s1;
      strb_s3    <= strb_s2;
      capture    <= next_capture;
      strobe_out <= next_strobe_out;
      strobe_oe  <= next_strobe_oe;
    end
  end

  assign strobe_pin_o        = strobe_out;
  assign strobe_pin_oe_o     = strobe_oe;
  assign strobe_capture_ff_o = capture;

  // buzzer, tape, indicator, strobe and interrupt checks
  buzz_mix_a: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && !(tape_play_s & beep_dis_n_s & rec_new_n_s & rec_leg_n_s))
    |=> buzzer_out_o)
    else $error("buzzer not high after a low mix input");
  play_in_a: assert property (@(posedge core_clk_i)
    disable iff (srst_i) (clk_en_i && !tape_play_s) |=> buzzer_out_o)
    else $error("playback low did not sound buzzer");
  buzz_quiet_a: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && tape_play_s && beep_dis_n_s && rec_new_n_s && rec_leg_n_s)
    |=> !buzzer_out_o)
    else $error("buzzer high with all inputs high");
  tape_rec_a: assert property (@(posedge core_clk_i)
    disable iff (srst_i) clk_en_i |=> (tape_rec_out_o == !$past(rec_leg_n_s)))
    else $error("tape record output mismatch");
  cpu_ind_a: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && cpu_active_i == SGP_CPU_LEGACY) |=> !cpu_select_ind_o)
    else $error("indicator high while legacy cpu runs");
  strobe_rst_a: assert property (@(posedge core_clk_i)
    (srst_i && clk_en_i) |=> !strobe_pin_oe_o && !strobe_pin_o)
    else $error("strobe pin driven during reset");
  strobe_dir_a: assert property (@(posedge core_clk_i)
    disable iff (srst_i) (clk_en_i && normal_mode_i) |=> strobe_pin_oe_o)
    else $error("strobe pin not output in normal mode");
  strobe_set_a: assert property (@(posedge core_clk_i)
    disable iff (srst_i) (clk_en_i && strobe_hit) |=> strobe_pin_o [*2])
    else $error("strobe did not rise and hold after write");
  irq_route_a: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (clk_en_i && irq_s && cpu_active_i == SGP_CPU_PRIMARY)
    |=> irq_primary_o && !irq_legacy_o)
    else $error("request not routed to primary cpu");

  buzz_cover_c:  cover property (@(posedge core_clk_i) $rose(buzzer_out_o));
  strobe_cover_c: cover property (@(posedge core_clk_i) $rose(strobe_pin_o));
  irq_cover_c:   cover property (@(posedge core_clk_i) $rose(irq_legacy_o));

endmodule

// File: core/sgp_sync.sv
/*
  sgp_sync: three-stage synchroniser per bit with agreement filter.
  assumes inputs are asynchronous pins; output changes once stages two
  and three agree.
*/
`timescale 1ns/10ps
module sgp_sync
  import sgp_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and control
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic             clk_en_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      // stage1 feeds stage2 only; filter compares stage2 and stage3
      always_comb begin
        next_sync[gi] = (stage2[gi] == stage3[gi]) ? stage3[gi] : sync_o[gi];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      sync_o <= RST_VAL;
    end else if (clk_en_i) begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_o <= next_sync;
    end
  end

endmodule

// File: inc/sgp_pkg.sv
/*
  sgp_pkg: constants and carrier structs for the system glue pin logic.
  assumes a single 20 MHz core clock and a synchronous active-high reset.
*/
package sgp_pkg;

  // core clock
  localparam int unsigned CLK_PERIOD_NS = 50;

  // width of the primary processor's port address and legacy memory address
  localparam int unsigned IO_ADDR_W  = 8;
  localparam int unsigned MEM_ADDR_W = 16;

  // strobe trigger addresses
  localparam logic [7:0]  STROBE_IO_ADDR  = 8'h18;
  localparam logic [15:0] STROBE_MEM_ADDR = 16'hf008;

  // reset input hold time held by the partner, and its cycle count
  localparam int unsigned RESET_HOLD_MS   = 30;
  localparam int unsigned RESET_HOLD_CYC  =
    (RESET_HOLD_MS * 1000000) / CLK_PERIOD_NS;

  // reset values
  localparam logic STROBE_OUT_RST = 1'b0;
  localparam logic CAPTURE_RST    = 1'b1;

  // synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;

  // which processor runs
  typedef enum logic [1:0] {
    SGP_CPU_LEGACY  = 2'b01,
    SGP_CPU_PRIMARY = 2'b10
  } sgp_cpu_t;

  // tape and beep inputs into the buzzer mix
  typedef struct packed {
    logic tape_play_in;
    logic beep_disable_n;
    logic tape_rec_new_n;
    logic tape_rec_legacy_n;
  } sgp_buzz_in_t;

  // write cycle seen on either processor bus
  typedef struct packed {
    logic                  io_wr;
    logic [IO_ADDR_W-1:0]  io_addr;
    logic                  mem_wr;
    logic                  mem_space_one;
    logic [MEM_ADDR_W-1:0] mem_addr;
  } sgp_wr_t;

  localparam int unsigned PIN_IN_W = 6;

endpackage
